// ### logic/gpst_defines.svh
// Purpose: offsets, field positions, reset values of the gpio strap port
// Assumes: 4-bit register address, 8-bit register data
// Notes:   included by the port module
`ifndef GPST_DEFINES_SVH
`define GPST_DEFINES_SVH

`define GPST_OFS_DIR      4'h0
`define GPST_OFS_DATA     4'h1
`define GPST_OFS_STATUS   4'h2
`define GPST_OFS_BOOT     4'h3

`define GPST_RST_DIR      8'h00
`define GPST_RST_DOUT     8'h00
`define GPST_RST_FLAG     1'b1

`define GPST_BOOT_DONE    0
`define GPST_BOOT_HS_EN   1

`define GPST_STS_CLK      3
`define GPST_STS_PP       4
`define GPST_STS_FLAG     5
`define GPST_STS_DONE     6
`define GPST_STS_HS       7

`define GPST_PIN_CLK      4
`define GPST_PIN_FUNC     6

`endif

// ### logic/gpst_pkg.sv
// Purpose: types of the gpio strap port
// Assumes: nothing
// Notes:   state of each module is one packed struct
package gpst_pkg;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] dout;
    logic       flag;
    logic [2:0] boot_sel;
    logic       clk_sel;
    logic       pp_mode;
    logic       strap_pending;
    logic       boot_done;
    logic       hs_en;
    logic [7:0] rdata;
  } gpst_state_type;

  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] stable;
  } gpst_sync_state_type;

endpackage : gpst_pkg

// ### logic/gpst_pin_if.sv
// Purpose: carries raw pin levels to the synchroniser and back
// Assumes: one clock domain on the consuming side
// Notes:   user side drives raw, sync side returns stable levels
`timescale 1ns/1ps
`default_nettype none

interface gpst_pin_if;
  logic [7:0] raw;
  logic [7:0] synced;

  modport sync_side (
    input  raw,
    output synced
  );

  modport user_side (
    output raw,
    input  synced
  );
endinterface : gpst_pin_if

`default_nettype wire

// ### logic/gpst_sync.sv
// Purpose: two-flop synchroniser for the eight port pins
// Assumes: pins are asynchronous to ref_clk
// Notes:   no reset, so straps are already settled when reset releases
`timescale 1ns/1ps
`default_nettype none

module gpst_sync
  import gpst_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   clk_en,
  gpst_pin_if.sync_side pins
);

  gpst_sync_state_type st;
  gpst_sync_state_type next_st;

  // first stage is read only by the second stage
  always_comb begin
    next_st        = st;
    next_st.meta   = pins.raw;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      st <= next_st;
    end
  end

  assign pins.synced = st.stable;

endmodule : gpst_sync

`default_nettype wire

// ### logic/gpst_port.sv
// Purpose: eight-pin general-purpose port with reset straps and flag pin
// Assumes: register strobes and flag controls come from ref_clk logic
// Notes:   reset acts even while clk_en is low
//
// Operation
// - per-pin direction set by software
// - read returns pin levels, write drives outputs
// - all pins inputs during and after reset
// - pins two to zero select boot mode
// - boot-select pins become ordinary after boot
// - pin four drives boot handshake when enabled
// - pin four low selects oscillator clock
// - pin four high selects external clock
// - pin four free for application after boot
// - pin six selects multiplexed pin function
// - flag set, clear, or cleared on status load
// - flag output high throughout reset
// - pins high impedance while in reset
`timescale 1ns/1ps
`default_nettype none
`include "gpst_defines.svh"

module gpst_port
  import gpst_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  input  wire logic       boot_handshake_level,
  input  wire logic       flag_set_instruction,
  input  wire logic       flag_clear_instruction,
  input  wire logic       status_word_one_load,
  output logic            latched_flag_output,
  output logic      [2:0] boot_select,
  output logic            input_clock_select_bit,
  output logic            parallel_port_io_mode
);

  localparam gpst_state_type RESET_STATE = '{
    dir:           `GPST_RST_DIR,
    dout:          `GPST_RST_DOUT,
    flag:          `GPST_RST_FLAG,
    boot_sel:      3'h0,
    clk_sel:       1'b0,
    pp_mode:       1'b0,
    strap_pending: 1'b1,
    boot_done:     1'b0,
    hs_en:         1'b0,
    rdata:         8'h00
  };

  gpst_state_type st;
  gpst_state_type next_st;
  gpst_pin_if     pins ();
  logic     [7:0] levels;
  logic     [7:0] oe_eff;
  logic           hs_drive;
  logic     [7:0] status_word;

  assign pins.raw = pin_in;
  assign levels   = pins.synced;

  gpst_sync u_sync (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .pins    (pins.sync_side)
  );

  // boot loader owns pin four until boot is declared done
  assign hs_drive = st.hs_en & ~st.boot_done;

  always_comb begin
    oe_eff    = st.dir;
    // boot-select pins stay inputs until boot is done
    oe_eff[2:0] = st.dir[2:0] & {3{st.boot_done}};
    if (hs_drive) begin
      oe_eff[4] = 1'b1;
    end else begin
      oe_eff[4] = st.dir[4] & st.boot_done;
    end
  end

  always_comb begin
    status_word                  = 8'h00;
    status_word[2:0]             = st.boot_sel;
    status_word[`GPST_STS_CLK]   = st.clk_sel;
    status_word[`GPST_STS_PP]    = st.pp_mode;
    status_word[`GPST_STS_FLAG]  = st.flag;
    status_word[`GPST_STS_DONE]  = st.boot_done;
    status_word[`GPST_STS_HS]    = st.hs_en;
  end

  always_comb begin
    next_st       = st;
    next_st.rdata = st.rdata;
    // straps are taken on the first enabled cycle after release;
    // the board keeps pin seven low here
    if (st.strap_pending) begin
      next_st.boot_sel      = levels[2:0];
      next_st.clk_sel       = levels[`GPST_PIN_CLK];
      next_st.pp_mode       = levels[`GPST_PIN_FUNC];
      next_st.strap_pending = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        `GPST_OFS_DIR: begin
          next_st.dir = reg_wdata;
        end
        `GPST_OFS_DATA: begin
          next_st.dout = reg_wdata;
        end
        `GPST_OFS_BOOT: begin
          // done is sticky until the next reset
          next_st.boot_done = st.boot_done
                            | reg_wdata[`GPST_BOOT_DONE];
          next_st.hs_en     = reg_wdata[`GPST_BOOT_HS_EN];
        end
        default: begin
          next_st.dir = st.dir;
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `GPST_OFS_DIR: begin
          next_st.rdata = st.dir;
        end
        `GPST_OFS_DATA: begin
          next_st.rdata = levels;
        end
        `GPST_OFS_STATUS: begin
          next_st.rdata = status_word;
        end
        `GPST_OFS_BOOT: begin
          next_st.rdata = {6'h00, st.hs_en, st.boot_done};
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
    // a set arriving with a clear wins
    if (flag_set_instruction) begin
      next_st.flag = 1'b1;
    end else if (flag_clear_instruction | status_word_one_load) begin
      next_st.flag = 1'b0;
    end
    if (rst) begin
      next_st = RESET_STATE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clk_en) begin
      st <= next_st;
    end
  end

  // pins float for the whole reset, not only after its first edge
  assign pin_oe  = rst ? 8'h00 : oe_eff;
  assign pin_out = {st.dout[7:5],
                    hs_drive ? boot_handshake_level : st.dout[4],
                    st.dout[3:0]};

  assign latched_flag_output    = st.flag | rst;
  assign reg_rdata              = st.rdata;
  assign boot_select            = st.boot_sel;
  assign input_clock_select_bit = st.clk_sel;
  assign parallel_port_io_mode  = st.pp_mode;

  // checks

  dir_write_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == `GPST_OFS_DIR
    |=> st.dir == $past(reg_wdata))
    else $error("direction write not stored");

  data_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `GPST_OFS_DATA
    |=> reg_rdata == $past(levels))
    else $error("data read does not return pin levels");

  data_drive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == `GPST_OFS_DATA
    |=> pin_out[7] == $past(reg_wdata[7]))
    else $error("data write not driven to pin");

  reset_inputs_a: assert property (
    @(posedge ref_clk)
    rst ##1 !rst |-> pin_oe == 8'h00 && st.dir == 8'h00)
    else $error("pin drives right after reset");

  reset_float_a: assert property (
    @(posedge ref_clk)
    rst |-> pin_oe == 8'h00)
    else $error("pin driven during reset");

  boot_strap_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && st.strap_pending |=> boot_select == $past(levels[2:0]))
    else $error("boot select not taken from pins");

  clk_osc_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && st.strap_pending && !levels[`GPST_PIN_CLK]
    |=> !input_clock_select_bit)
    else $error("oscillator clock not selected");

  clk_ext_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && st.strap_pending && levels[`GPST_PIN_CLK]
    |=> input_clock_select_bit)
    else $error("external clock not selected");

  func_strap_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && st.strap_pending
    |=> parallel_port_io_mode == $past(levels[`GPST_PIN_FUNC]))
    else $error("function select not taken from pin six");

  strap_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !st.strap_pending ##1 !rst
    |-> $stable(boot_select) && $stable(input_clock_select_bit)
        && $stable(parallel_port_io_mode) && !st.strap_pending)
    else $error("strap value changed after capture");

  boot_gpio_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    st.boot_done |-> pin_oe[2:0] == st.dir[2:0])
    else $error("boot pins not free after boot");

  hs_drive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !st.boot_done && st.hs_en
    |-> pin_oe[4] && pin_out[4] == boot_handshake_level)
    else $error("handshake not driven on pin four");

  pin4_free_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    st.boot_done |-> pin_oe[4] == st.dir[4]
                  && pin_out[4] == st.dout[4])
    else $error("pin four not free after boot");

  flag_set_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && flag_set_instruction |=> latched_flag_output)
    else $error("flag not set");

  flag_clear_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && !flag_set_instruction
    && (flag_clear_instruction || status_word_one_load)
    |=> !latched_flag_output)
    else $error("flag not cleared");

  flag_reset_a: assert property (
    @(posedge ref_clk)
    rst ##1 rst |-> latched_flag_output && st.flag)
    else $error("flag low during reset");

  dir_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `GPST_OFS_DIR
    |=> reg_rdata == $past(st.dir))
    else $error("direction read wrong");

  status_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `GPST_OFS_STATUS
    |=> reg_rdata[2:0] == $past(boot_select)
        && reg_rdata[3] == $past(input_clock_select_bit)
        && reg_rdata[4] == $past(parallel_port_io_mode))
    else $error("status read wrong");

  boot_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == `GPST_OFS_BOOT
    |=> reg_rdata == {6'h00, $past(st.hs_en), $past(st.boot_done)})
    else $error("boot control read wrong");

  rdata_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(clk_en && reg_rd)
    |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  set_wins_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && flag_set_instruction
    && (flag_clear_instruction || status_word_one_load)
    |=> latched_flag_output)
    else $error("flag clear overrode a set");

  flag_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !flag_set_instruction && !flag_clear_instruction && !status_word_one_load
    |=> $stable(latched_flag_output))
    else $error("flag changed with no instruction");

  strap_once_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && st.strap_pending |=> !st.strap_pending)
    else $error("strap capture not closed");

  pending_reset_a: assert property (
    @(posedge ref_clk)
    rst ##1 rst |-> st.strap_pending)
    else $error("strap capture not armed by reset");

  early_boot_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !st.boot_done |-> pin_oe[2:0] == 3'h0)
    else $error("boot pins driven before boot done");

  hs_quiet_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !st.boot_done && !st.hs_en |-> !pin_oe[4])
    else $error("pin four driven without handshake");

  data_low_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == `GPST_OFS_DATA
    |=> pin_out[3:0] == $past(reg_wdata[3:0])
        && pin_out[6:5] == $past(reg_wdata[6:5]))
    else $error("data write not driven to low pins");

  done_sticky_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    st.boot_done |=> st.boot_done)
    else $error("boot done dropped before reset");

  dir_oe_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    pin_oe[7:5] == st.dir[7:5] && pin_oe[3] == st.dir[3])
    else $error("free pin enable differs from direction");

  freeze_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !clk_en |=> $stable(st.dir) && $stable(st.dout)
                && $stable(st.flag) && $stable(st.rdata))
    else $error("state moved while clock enable low");

endmodule : gpst_port

`default_nettype wire

// ### tb/gpst_board.sv
// Purpose: board side of the eight port pins
// Assumes: the board drives every pin that the device leaves released
// Notes:   strap levels come from board_val, pin seven low at release
`timescale 1ns/1ps
`default_nettype none

module gpst_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] board_val,
  output logic      [7:0] pin_in
);
  // a pin follows the device where it drives, else the board
  assign pin_in = (pin_out & pin_oe) | (board_val & ~pin_oe);
endmodule : gpst_board

`default_nettype wire

// ### tb/test_gpst_port.sv
// Purpose: self-checking bench of the gpio strap port
// Assumes: clk_en high except around one frozen write, board drives all released pins
// Notes:   a second reset covers the other clock and function strap levels
`timescale 1ns/1ps
`default_nettype none

module test_gpst_port;
  logic        ref_clk, rst, clk_en, reg_wr, reg_rd, hs_lvl;
  logic        f_set, f_clr, st_load, flag, clk_sel, pp_mode;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, pin_in, pin_out, pin_oe;
  logic [7:0]  board_val, rd;
  logic [2:0]  boot_sel;
  logic [47:0] rows [3];
  int          num_errors, comparisons;

  gpst_port DUT (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .boot_handshake_level(hs_lvl),
    .flag_set_instruction(f_set), .flag_clear_instruction(f_clr),
    .status_word_one_load(st_load), .latched_flag_output(flag),
    .boot_select(boot_sel), .input_clock_select_bit(clk_sel),
    .parallel_port_io_mode(pp_mode));

  gpst_board board (.pin_out(pin_out), .pin_oe(pin_oe),
    .board_val(board_val), .pin_in(pin_in));

  task automatic chk(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd_reg

  task automatic do_reset(input logic [7:0] straps);
    @(posedge ref_clk);
    board_val <= straps;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("oe in reset", pin_oe, 8'h00);
    chk("flag in reset", {7'h00, flag}, 8'h01);
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : do_reset

  task automatic flag_op(input logic [2:0] op, input logic e);
    @(posedge ref_clk);
    {f_set, f_clr, st_load} <= op;
    @(posedge ref_clk);
    {f_set, f_clr, st_load} <= 3'h0;
    #1 chk("flag", {7'h00, flag}, {7'h00, e});
  endtask : flag_op

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    num_errors++;
    complete_run();
  end

  initial begin
    {rst, clk_en, reg_wr, reg_rd, hs_lvl} = 5'b11000;
    {f_set, f_clr, st_load} = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    board_val = 8'h15;
    num_errors = 0;
    comparisons = 0;
    // fields: boot ctrl, dir, dout, board, pin_oe, data read
    rows = '{48'h00F0_A50F_E0AF, 48'h00FF_3C00_E828, 48'h011F_5A30_1F3A};
    do_reset(8'h15); // pin seven low at release
    chk("boot select", {5'h00, boot_sel}, 8'h05);
    chk("clock select", {7'h00, clk_sel}, 8'h01);
    chk("pp mode", {7'h00, pp_mode}, 8'h00);
    rd_reg(4'h2, rd);
    chk("status", rd, 8'h2D);
    wr(4'h2, 8'h00);
    rd_reg(4'h2, rd);
    chk("status ro", rd, 8'h2D);
    rd_reg(4'hF, rd);
    chk("unmapped", rd, 8'h00);
    foreach (rows[i]) begin
      board_val = rows[i][23:16];
      wr(4'h3, rows[i][47:40]);
      wr(4'h0, rows[i][39:32]);
      wr(4'h1, rows[i][31:24]);
      repeat (3) @(posedge ref_clk);
      rd_reg(4'h0, rd);
      chk("dir read", rd, rows[i][39:32]);
      rd_reg(4'h1, rd);
      chk("data read", rd, rows[i][7:0]);
      chk("pin_oe", pin_oe, rows[i][15:8]);
      chk("pin_out", pin_out & pin_oe,
          rows[i][31:24] & rows[i][15:8]);
    end
    flag_op(3'b110, 1'b1);
    flag_op(3'b010, 1'b0);
    flag_op(3'b100, 1'b1);
    flag_op(3'b001, 1'b0);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(4'h0, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd_reg(4'h0, rd);
    chk("frozen dir", rd, 8'h1F);
    do_reset(8'h40);
    chk("clock select", {7'h00, clk_sel}, 8'h00);
    chk("pp mode", {7'h00, pp_mode}, 8'h01);
    board_val = 8'h1F;
    repeat (4) @(posedge ref_clk);
    #1 chk("strap hold", {4'h0, clk_sel, boot_sel}, 8'h00);
    @(posedge ref_clk);
    hs_lvl <= 1'b1;
    wr(4'h3, 8'h02);
    #1 chk("handshake", {6'h00, pin_oe[4], pin_out[4]}, 8'h03);
    complete_run();
  end
endmodule : test_gpst_port

`default_nettype wire
